// File: dv/mdsp_line_partner.sv
// Purpose: Far station sharing the serial line
// Assumes: send is called just after a rising clock edge
// Notes:   One bit lasts BIT_CLKS clocks both ways
`timescale 1ns/10ps
module mdsp_line_partner #(
  parameter int BIT_CLKS = 64
) (
  input  wire logic ref_clk,
  input  wire logic txd,
  output logic      rxd
);
  int         nbits = 8;
  int         frames = 0;
  int         gap = 0;
  int         tick = 0;
  int         last_start = 0;
  logic [9:0] sh;
  logic [7:0] got_data;
  logic       got_flag;
  logic       got_stop;

  initial rxd = 1'b1;

  // One bit period on the line
  task automatic bit_out(input logic b);
    rxd <= b;
    repeat (BIT_CLKS) @(posedge ref_clk);
  endtask : bit_out

  // Bad stop is followed by a high bit so the line returns to idle
  task automatic send(input logic [7:0] d, input logic flag,
                      input logic stop_ok);
    bit_out(1'b0);
    for (int i = 0; i < nbits; i++) bit_out(d[i]);
    bit_out(flag);
    bit_out(stop_ok);
    if (!stop_ok) bit_out(1'b1);
  endtask : send

  always @(posedge ref_clk) tick <= tick + 1;

  // Decode each frame at mid-bit; gap is start-to-start spacing
  always begin
    @(negedge txd);
    gap = tick - last_start;
    last_start = tick;
    repeat (BIT_CLKS / 2) @(posedge ref_clk);
    for (int i = 0; i < nbits + 2; i++) begin
      repeat (BIT_CLKS) @(posedge ref_clk);
      sh[i] = txd;
    end
    got_data = sh[7:0] & ~(8'hff << nbits);
    got_flag = sh[nbits];
    got_stop = sh[nbits + 1];
    frames++;
  end
endmodule : mdsp_line_partner

// File: dv/mdsp_port_bench.sv
// Purpose: Self-checking bench for mdsp_port
// Assumes: Divisor 1 gives 64 clocks per bit
// Notes:   DMA write path held inactive, clock enable held active
`timescale 1ns/10ps
module mdsp_port_bench;
  import mdsp_pkg::*;
  localparam int BT = 64;
  logic                   ref_clk, rstn, clk_en, avs_read, avs_write;
  logic [MDSP_ADDR_W-1:0] avs_address;
  logic [31:0]            avs_writedata, avs_readdata;
  logic [3:0]             avs_byteenable;
  logic                   avs_waitrequest, dma_tx_wr, dma_rx_rd, rxd, txd;
  logic [7:0]             dma_tx_data, dma_rx_data;
  logic                   tx_empty_irq, rx_full_irq, rx_fault_irq;
  logic                   tx_done_irq;
  int                     errors = 0;
  int                     comparisons = 0;

  mdsp_port dut (.*);
  mdsp_line_partner #(.BIT_CLKS(BT)) line_peer (
    .ref_clk(ref_clk), .txd(txd), .rxd(rxd));

  always #25 ref_clk = ~ref_clk;

  task automatic report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic check(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  // Hold the request until waitrequest is sampled low
  task automatic bus(input logic [23:0] idx, input logic wr,
                     input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    avs_address   <= {2'h0, idx};
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= {24'h0, wd};
    do begin @(posedge ref_clk); n++; end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata[7:0];
    if (n >= 50) errors++;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge ref_clk);
  endtask : bus

  task automatic wr(input logic [23:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(idx, 1'b1, d, x);
  endtask : wr

  task automatic rdc(input logic [23:0] idx, input logic [7:0] exp,
                     input string nm, input logic [7:0] m = 8'hff);
    logic [7:0] v;
    bus(idx, 1'b0, 8'h00, v);
    check(nm, {24'h0, v & m}, {24'h0, exp & m});
  endtask : rdc

  // Wait for an empty hold, then load a byte with its address flag
  task automatic load(input logic [7:0] d, input logic m);
    logic [7:0] v;
    v = 8'h00;
    for (int k = 0; k < 400 && !v[7]; k++) bus(MDSP_IDX_FLAGS, 1'b0, 0, v);
    wr(MDSP_IDX_TX_HOLD, d);
    // Any flags write forgets the read, so clear and flag in one write
    wr(MDSP_IDX_FLAGS, {1'b0, 6'h3f, m});
  endtask : load

  task automatic wait_tx(input int n);
    while (line_peer.frames < n) @(posedge ref_clk);
  endtask : wait_tx

  task automatic t_reset;
    rdc(MDSP_IDX_LINE_FMT, 8'h00, "fmt");
    rdc(MDSP_IDX_CTRL, 8'h00, "ctrl");
    rdc(MDSP_IDX_FLAGS, 8'h84, "flags");
    rdc(MDSP_IDX_BAUD, 8'h20, "baud");
    wr(24'hfffe91, 8'hff);
    rdc(24'hfffe91, 8'h00, "unmapped");
    check("irqs", {tx_empty_irq, rx_full_irq, rx_fault_irq, tx_done_irq}, 0);
  endtask : t_reset

  // Back-to-back frames in the four multidrop formats
  task automatic t_tx;
    logic [7:0] f, mk;
    int n0, nb;
    wr(MDSP_IDX_BAUD, 8'h01);
    rdc(MDSP_IDX_BAUD, 8'h01, "baud");
    for (int c = 0; c < 4; c++) begin
      f = {1'b0, c[1], 2'b00, c[0], 3'b100};
      nb = c[1] ? 7 : 8;
      mk = c[1] ? 8'h7f : 8'hff;
      line_peer.nbits = nb;
      n0 = line_peer.frames;
      wr(MDSP_IDX_LINE_FMT, f);
      wr(MDSP_IDX_CTRL, 8'ha4);
      check("txi", tx_empty_irq, 1);
      load(8'hb8, 1'b1);
      load(8'hde, 1'b0);
      wait_tx(n0 + 1);
      check("data1", line_peer.got_data, 8'hb8 & mk);
      check("flag1", line_peer.got_flag, 1);
      wait_tx(n0 + 2);
      check("data2", line_peer.got_data, 8'hde & mk);
      check("flag2", line_peer.got_flag, 0);
      check("stop", line_peer.got_stop, 1);
      check("gap", line_peer.gap, (nb + 3 + c[0]) * BT);
      repeat (2 * BT) @(posedge ref_clk);
      check("tei", tx_done_irq, 1);
      wr(MDSP_IDX_CTRL, 8'h00);
      rdc(MDSP_IDX_FLAGS, 8'h84, "off");
    end
  endtask : t_tx

  // Overrun, disabled receiver and DMA read
  task automatic t_rx;
    line_peer.nbits = 8;
    wr(MDSP_IDX_LINE_FMT, 8'h0c);
    wr(MDSP_IDX_CTRL, 8'h50);
    line_peer.send(8'h3c, 1'b1, 1'b1);
    line_peer.send(8'hc3, 1'b1, 1'b1);
    rdc(MDSP_IDX_FLAGS, 8'he6, "ovr");
    check("rxirq", {rx_full_irq, rx_fault_irq}, 2'b11);
    rdc(MDSP_IDX_RX_HOLD, 8'h3c, "hold");
    wr(MDSP_IDX_CTRL, 8'h40);
    line_peer.send(8'h55, 1'b0, 1'b0);
    rdc(MDSP_IDX_FLAGS, 8'he6, "rxoff");
    check("dma", dma_rx_data, 8'h3c);
    dma_rx_rd <= 1'b1;
    @(posedge ref_clk);
    dma_rx_rd <= 1'b0;
    rdc(MDSP_IDX_FLAGS, 8'ha6, "dmard");
    wr(MDSP_IDX_FLAGS, 8'hde);
    rdc(MDSP_IDX_FLAGS, 8'h86, "clr");
    check("rxirq0", {rx_full_irq, rx_fault_irq}, 2'b00);
  endtask : t_rx

  // Address wait, address-frame wake-up, framing error
  task automatic t_addr;
    wr(MDSP_IDX_CTRL, 8'h58);
    line_peer.send(8'h11, 1'b0, 1'b0);
    rdc(MDSP_IDX_FLAGS, 8'h84, "skip", 8'hfd);
    line_peer.send(8'h01, 1'b1, 1'b1);
    rdc(MDSP_IDX_CTRL, 8'h50, "wake");
    rdc(MDSP_IDX_FLAGS, 8'hc6, "id");
    rdc(MDSP_IDX_RX_HOLD, 8'h01, "idv");
    wr(MDSP_IDX_FLAGS, 8'hbe);
    line_peer.send(8'hde, 1'b0, 1'b0);
    rdc(MDSP_IDX_FLAGS, 8'h94, "fer");
    check("eri", rx_fault_irq, 1);
    wr(MDSP_IDX_FLAGS, 8'hee);
    rdc(MDSP_IDX_FLAGS, 8'h84, "ferclr");
  endtask : t_addr

  // Cut a hang short
  initial begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    report_and_stop;
  end

  initial begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    clk_en = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
    dma_tx_wr = 1'b0;
    dma_tx_data = 8'h00;
    dma_rx_rd = 1'b0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_reset;
    t_tx;
    t_rx;
    t_addr;
    report_and_stop;
  end
endmodule : mdsp_port_bench

bind mdsp_port mdsp_port_checker #(.BIT_CLKS(64)) chk (.*);

// File: dv/mdsp_port_properties.sv
// Purpose: Port-level assertions for mdsp_port
// Assumes: Control bits shadowed from acknowledged bus writes
// Notes:   BIT_CLKS must match the divisor the bench programs
`timescale 1ns/10ps
module mdsp_port_checker #(
  parameter int BIT_CLKS = 64
) (
  input wire logic                              ref_clk,
  input wire logic                              rstn,
  input wire logic [mdsp_pkg::MDSP_ADDR_W-1:0]  avs_address,
  input wire logic                              avs_read,
  input wire logic                              avs_write,
  input wire logic [31:0]                       avs_writedata,
  input wire logic [3:0]                        avs_byteenable,
  input wire logic                              avs_waitrequest,
  input wire logic                              txd,
  input wire logic                              tx_empty_irq,
  input wire logic                              rx_full_irq,
  input wire logic                              rx_fault_irq,
  input wire logic                              tx_done_irq
);
  import mdsp_pkg::*;
  logic [7:0] ctl_reg;
  logic       txd_q;
  int         run;

  // Shadow of control writes; auto-clear touches only bit 3
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) ctl_reg <= 8'h00;
    else if (avs_write && !avs_waitrequest &&
             avs_address[23:0] == MDSP_IDX_CTRL)
      ctl_reg <= avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
  end

  // Length of the current txd level in clocks
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      txd_q <= 1'b1;
      run   <= 0;
    end else begin
      txd_q <= txd;
      run   <= (txd != txd_q) ? 0 : run + 1;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence req_s; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence tx_off_s; !ctl_reg[MDSP_SC_TE] [*2]; endsequence

  bus_answer_a:
    assert property (req_s |=> !avs_waitrequest)
    else $error("bus request not answered after one cycle");
  tx_empty_gate_a:
    assert property (tx_empty_irq |-> ctl_reg[MDSP_SC_TIE])
    else $error("transmit-empty request while disabled");
  rx_irq_gate_a:
    assert property ((rx_full_irq || rx_fault_irq) |-> ctl_reg[MDSP_SC_RIE])
    else $error("receive request while disabled");
  tx_done_gate_a:
    assert property (tx_done_irq |-> ctl_reg[MDSP_SC_TX_DONE_IRQ_EN])
    else $error("transmit-end request while disabled");
  tx_off_idle_a:
    assert property (tx_off_s |-> txd)
    else $error("txd low with transmitter disabled");
  hold_empty_off_a:
    assert property (tx_off_s ##0 ctl_reg[MDSP_SC_TIE] |-> tx_empty_irq)
    else $error("hold not empty with transmitter disabled");
  idle_off_a:
    assert property (tx_off_s ##0 ctl_reg[MDSP_SC_TX_DONE_IRQ_EN] |-> tx_done_irq)
    else $error("transmit end not flagged while disabled");
  low_run_a:
    assert property (txd && !txd_q |-> (run + 1) % BIT_CLKS == 0)
    else $error("low run on txd not whole bit times");
endmodule : mdsp_port_checker

// File: include/mdsp_pkg.sv
// Purpose: Constants for the multidrop async serial port
// Assumes: Avalon-MM word-addressed slave, 20 MHz ref_clk
// Notes:   Printed offsets are not all multiples of four
package mdsp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [23:0] MDSP_IDX_LINE_FMT = 24'hfffe90;
  localparam logic [23:0] MDSP_IDX_CTRL     = 24'hfffe92;
  localparam logic [23:0] MDSP_IDX_TX_HOLD  = 24'hfffe93;
  localparam logic [23:0] MDSP_IDX_FLAGS    = 24'hfffe94;
  localparam logic [23:0] MDSP_IDX_RX_HOLD  = 24'hfffe95;
  localparam logic [23:0] MDSP_IDX_BAUD     = 24'hfffe97;
  localparam int MDSP_ADDR_W = 26;
  // Line format fields
  localparam int MDSP_LF_SYNC  = 7;
  localparam int MDSP_LF_CHR   = 6;
  localparam int MDSP_LF_STOP  = 3;
  localparam int MDSP_LF_MP    = 2;
  localparam int MDSP_LF_BAUD_CLK_DIV_SEL_HI  = 1;
  localparam int MDSP_LF_BAUD_CLK_DIV_SEL_LO  = 0;
  // Control fields
  localparam int MDSP_SC_TIE   = 7;
  localparam int MDSP_SC_RIE   = 6;
  localparam int MDSP_SC_TE    = 5;
  localparam int MDSP_SC_RE    = 4;
  localparam int MDSP_SC_ADDR_WAIT_MODE  = 3;
  localparam int MDSP_SC_TX_DONE_IRQ_EN  = 2;
  // Status fields
  localparam int MDSP_SF_TX_HOLD_EMPTY  = 7;
  localparam int MDSP_SF_RX_HOLD_FULL  = 6;
  localparam int MDSP_SF_OVERRUN_FLAG  = 5;
  localparam int MDSP_SF_FER   = 4;
  localparam int MDSP_SF_TX_IDLE_FLAG  = 2;
  localparam int MDSP_SF_MPB   = 1;
  localparam int MDSP_SF_TX_ADDR_FLAG_BIT  = 0;
  // Reset values
  localparam logic [7:0] MDSP_RST_LINE_FMT = 8'h00;
  localparam logic [7:0] MDSP_RST_CTRL     = 8'h00;
  localparam logic [7:0] MDSP_RST_BAUD     = 8'h20;
  localparam logic [7:0] MDSP_RST_FLAGS    = 8'h84;
  // Timing: divisor 32 at 20 MHz gives 19200 bps with 1056 clocks per bit
  localparam int MDSP_CLK_HZ       = 20000000;
  localparam int MDSP_BAUD_BPS     = 19200;
  localparam int MDSP_OVERSAMPLE   = 16;
  localparam int MDSP_TICKS_PER_BIT = 16;
  localparam int MDSP_DIV_MULT     = 2;
  localparam logic [3:0] MDSP_MID_TICK = 4'h7;
endpackage : mdsp_pkg

// File: src/mdsp_port.sv
// Purpose: Async serial port with multidrop addressing and Avalon slave
// Assumes: Single 20 MHz clock, rxd asynchronous to it
// Notes:   Bit time = 2*16*(divisor+1) clocks; sync mode not built
`timescale 1ns/10ps
// Summary of operation
// - Sync-mode bit 7 selects async (0); sync mode halts transmitter and receiver.
// - Character length 8 bits when char_len_sel is 0, else 7.
// - Stop bit count one or two from line format bit 3.
// - Receiver checks first stop bit only; low second stop starts frame.
// - Multidrop_mode adds address-flag bit to every frame.
// - Baud prescaler select 00 uses ref_clk directly.
// - Eight-bit baud divisor; 32 at 20 MHz gives 19200 bps.
// - tx_empty_irq forwarded only while tx_empty_irq_en set.
// - rx_full_irq and rx_fault_irq forwarded only with rx_full_irq_en.
// - Transmitter runs only while tx_en is set.
// - Receiver runs only while rx_en is set.
// - Address wait discards frames with address flag 0, no flags set.
// - Address frame sets rx_addr_flag_bit and clears addr_wait_mode.
// - tx_done_irq forwarded only while tx_done_irq_en set.
// - Clock source select 00 takes bit clock from baud generator.
// - tx_hold_empty set when tx_en low or hold copied to shifter.
// - tx_hold_empty cleared by read-1 then write-0, or DMA write.
// - rx_hold_full set on good frame; cleared by read-then-0 or DMA.
// - rx_hold_full keeps its value when rx_en is cleared.
// - Frame done while full sets overrun_flag and drops frame.
// - Framing error sets framing_flag; cleared by read-then-write-0.
// - Received address flag captured; unchanged while rx_en low.
// - tx_addr_flag_bit is sent as each frame's address flag.
// - tx_idle_flag set when tx_en low or last bit sent with empty hold.
module mdsp_port (
  input  wire logic                          ref_clk,
  input  wire logic                          rstn,
  input  wire logic                          clk_en,
  input  wire logic [mdsp_pkg::MDSP_ADDR_W-1:0] avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic [31:0]                        avs_readdata,
  output logic                               avs_waitrequest,
  input  wire logic                          dma_tx_wr,
  input  wire logic [7:0]                    dma_tx_data,
  input  wire logic                          dma_rx_rd,
  output logic [7:0]                         dma_rx_data,
  input  wire logic                          rxd,
  output logic                               txd,
  output logic                               tx_empty_irq,
  output logic                               rx_full_irq,
  output logic                               rx_fault_irq,
  output logic                               tx_done_irq
);
  import mdsp_pkg::*;

  typedef enum logic [1:0] {
    MDSP_IDLE = 2'b00, MDSP_START = 2'b01, MDSP_DATA = 2'b11,
    MDSP_STOP = 2'b10
  } mdsp_state_e;

  logic [7:0]  line_fmt_reg;
  logic [7:0]  ctrl_reg;
  logic [7:0]  tx_hold_reg;
  logic [7:0]  baud_reg;
  logic [7:0]  rx_hold_reg;
  logic        tx_hold_empty_reg, rx_hold_full_reg, overrun_flag_reg, fer_reg;
  logic        tx_idle_flag_reg, mpb_reg, tx_addr_flag_bit_reg;
  logic [7:0]  flags_seen_reg;
  logic        ack_reg;
  logic [23:0] idx;
  logic        acc, wr_fire, rd_fire;
  logic [7:0]  wbyte;
  logic [7:0]  flags_now;

  // Controls decoded from the format and control registers
  logic tx_en, rx_en, mp_on, addr_wait_mode, seven, two_stop, bclk_ok;
  assign tx_en    = ctrl_reg[MDSP_SC_TE];
  assign rx_en    = ctrl_reg[MDSP_SC_RE];
  assign mp_on    = line_fmt_reg[MDSP_LF_MP] &
                    ~line_fmt_reg[MDSP_LF_SYNC];
  assign addr_wait_mode     = ctrl_reg[MDSP_SC_ADDR_WAIT_MODE];
  assign seven    = line_fmt_reg[MDSP_LF_CHR];
  assign two_stop = line_fmt_reg[MDSP_LF_STOP];
  // Only async with internal baud clock is built; other modes hold still
  assign bclk_ok  = ~line_fmt_reg[MDSP_LF_SYNC] &
                    (line_fmt_reg[MDSP_LF_BAUD_CLK_DIV_SEL_HI:MDSP_LF_BAUD_CLK_DIV_SEL_LO] == 2'b00) &
                    (ctrl_reg[1:0] == 2'b00);

  // Bus decode: word address is index, one wait cycle per access
  assign idx     = avs_address[23:0];
  assign acc     = (avs_read | avs_write) & clk_en;
  assign wr_fire = avs_write & ack_reg & clk_en;
  assign rd_fire = avs_read & ack_reg & clk_en;
  assign wbyte   = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign flags_now = {tx_hold_empty_reg, rx_hold_full_reg, overrun_flag_reg, fer_reg, 1'b0,
                      tx_idle_flag_reg, mpb_reg, tx_addr_flag_bit_reg};

  // Acknowledge toggles one cycle after request appears
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
    end else if (clk_en) begin
      ack_reg <= acc & ~ack_reg;
    end
  end

  // Read data registered at the wait-cycle edge, one before accepting; unmapped reads zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en && avs_read && !ack_reg) begin
      case (idx)
        MDSP_IDX_LINE_FMT: avs_readdata <= {24'h0, line_fmt_reg};
        MDSP_IDX_CTRL:     avs_readdata <= {24'h0, ctrl_reg};
        MDSP_IDX_TX_HOLD:  avs_readdata <= {24'h0, tx_hold_reg};
        MDSP_IDX_FLAGS:    avs_readdata <= {24'h0, flags_now};
        MDSP_IDX_RX_HOLD:  avs_readdata <= {24'h0, rx_hold_reg};
        MDSP_IDX_BAUD:     avs_readdata <= {24'h0, baud_reg};
        default:           avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Plain read/write configuration registers
  logic addr_wait_mode_clr;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      line_fmt_reg <= MDSP_RST_LINE_FMT;
      ctrl_reg     <= MDSP_RST_CTRL;
      baud_reg     <= MDSP_RST_BAUD;
    end else if (clk_en) begin
      if (wr_fire && idx == MDSP_IDX_LINE_FMT) line_fmt_reg <= wbyte;
      if (wr_fire && idx == MDSP_IDX_BAUD)     baud_reg     <= wbyte;
      if (wr_fire && idx == MDSP_IDX_CTRL) begin
        ctrl_reg <= wbyte;
      end else if (addr_wait_mode_clr) begin
        ctrl_reg[MDSP_SC_ADDR_WAIT_MODE] <= 1'b0;
      end
    end
  end

  // Remember which flags software has seen as 1
  logic flags_rd;
  assign flags_rd = rd_fire && idx == MDSP_IDX_FLAGS;
  logic flags_wr;
  assign flags_wr = wr_fire && idx == MDSP_IDX_FLAGS;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flags_seen_reg <= 8'h00;
    end else if (clk_en) begin
      if (flags_rd) flags_seen_reg <= flags_now;
      else if (flags_wr) flags_seen_reg <= 8'h00;
    end
  end
  // A flag clears only if written 0 after being read as 1
  function automatic logic clr_ok(input int b);
    clr_ok = flags_wr & ~wbyte[b] & flags_seen_reg[b];
  endfunction : clr_ok

  // Baud generator: 16 ticks per bit, tick every 2*(N+1) clocks
  logic [8:0] baud_cnt_reg;
  logic       tick;
  assign tick = bclk_ok &&
                baud_cnt_reg == {baud_reg, 1'b1};
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      baud_cnt_reg <= 9'h000;
    end else if (clk_en) begin
      baud_cnt_reg <= tick ? 9'h000 : baud_cnt_reg + 9'h001;
    end
  end

  // Receiver synchroniser, second stage is the only reader of first
  logic rx_s1_reg, rx_s2_reg;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
    end else if (clk_en) begin
      rx_s1_reg <= rxd;
      rx_s2_reg <= rx_s1_reg;
    end
  end

  // Transmitter
  mdsp_state_e tx_st_reg;
  logic [9:0]  tx_sh_reg;
  logic [3:0]  tx_tick_reg, tx_bits_reg;
  logic        tx_load, tx_last;
  logic [3:0]  tx_nbits;
  assign tx_nbits = 4'(8 - (seven ? 1 : 0) + (mp_on ? 1 : 0)
                    + (two_stop ? 1 : 0));
  // Load on a tick only, so the start bit lasts a whole bit time
  assign tx_load = tx_en && bclk_ok && tx_st_reg == MDSP_IDLE
                   && !tx_hold_empty_reg && tick;
  // Stop ends one tick early; the load tick completes the bit
  assign tx_last = tick && tx_tick_reg == 4'he &&
                   tx_st_reg == MDSP_STOP && tx_bits_reg == 4'h0;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_st_reg   <= MDSP_IDLE;
      tx_sh_reg   <= 10'h3ff;
      tx_tick_reg <= 4'h0;
      tx_bits_reg <= 4'h0;
      txd         <= 1'b1;
    end else if (clk_en) begin
      if (!tx_en) begin
        tx_st_reg <= MDSP_IDLE;
        txd       <= 1'b1;
      end else if (tx_load) begin
        // Data LSB first, then address flag, then stop ones
        tx_sh_reg <= seven ?
          {1'b1, mp_on ? {1'b1, tx_addr_flag_bit_reg} : 2'b11, tx_hold_reg[6:0]} :
          {mp_on ? {1'b1, tx_addr_flag_bit_reg} : 2'b11, tx_hold_reg};
        tx_st_reg   <= MDSP_START;
        tx_tick_reg <= 4'h0;
        txd         <= 1'b0;
      end else if (tick) begin
        tx_tick_reg <= tx_tick_reg + 4'h1;
        if (tx_tick_reg == 4'hf) begin
          case (tx_st_reg)
            MDSP_START: begin
              tx_st_reg   <= MDSP_DATA;
              tx_bits_reg <= tx_nbits;
              txd         <= tx_sh_reg[0];
              tx_sh_reg   <= {1'b1, tx_sh_reg[9:1]};
            end
            MDSP_DATA: begin
              tx_bits_reg <= tx_bits_reg - 4'h1;
              txd         <= tx_sh_reg[0];
              tx_sh_reg   <= {1'b1, tx_sh_reg[9:1]};
              if (tx_bits_reg == 4'h1) tx_st_reg <= MDSP_STOP;
            end
            MDSP_STOP: begin
              tx_st_reg <= MDSP_IDLE;
              txd       <= 1'b1;
            end
            default: tx_st_reg <= MDSP_IDLE;
          endcase
        end
        if (tx_st_reg == MDSP_STOP && tx_tick_reg == 4'he)
          tx_st_reg <= MDSP_IDLE;
      end
    end
  end

  // Transmit flags and holding word
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_hold_reg <= 8'h00;
      tx_hold_empty_reg    <= 1'b1;
      tx_idle_flag_reg    <= 1'b1;
      tx_addr_flag_bit_reg    <= 1'b0;
    end else if (clk_en) begin
      if (dma_tx_wr) tx_hold_reg <= dma_tx_data;
      else if (wr_fire && idx == MDSP_IDX_TX_HOLD) tx_hold_reg <= wbyte;
      if (flags_wr) tx_addr_flag_bit_reg <= wbyte[MDSP_SF_TX_ADDR_FLAG_BIT];
      if (!tx_en || tx_load) tx_hold_empty_reg <= 1'b1;
      else if (dma_tx_wr || clr_ok(MDSP_SF_TX_HOLD_EMPTY)) tx_hold_empty_reg <= 1'b0;
      if (!tx_en || (tx_last && tx_hold_empty_reg)) tx_idle_flag_reg <= 1'b1;
      else if (dma_tx_wr || clr_ok(MDSP_SF_TX_HOLD_EMPTY)) tx_idle_flag_reg <= 1'b0;
    end
  end

  // Receiver: samples mid bit; first stop checked only
  mdsp_state_e rx_st_reg;
  logic [8:0]  rx_sh_reg;
  logic [3:0]  rx_tick_reg, rx_bits_reg;
  logic        rx_done, rx_bad, rx_mpb, rx_keep;
  logic [7:0]  rx_word;
  logic [3:0]  rx_nbits;
  assign rx_nbits = 4'(8 - (seven ? 1 : 0) + (mp_on ? 1 : 0));
  // Stop is judged at its centre, like the data bits
  assign rx_done  = rx_st_reg == MDSP_STOP && tick &&
                    rx_tick_reg == 4'hf;
  assign rx_bad   = ~rx_s2_reg;
  assign rx_mpb   = mp_on & rx_sh_reg[8];
  // Extra shift without multidrop gives each character length its multidrop alignment
  assign rx_word  = seven ? {1'b0, rx_sh_reg[7:1]} : rx_sh_reg[7:0];
  assign rx_keep  = !(mp_on && addr_wait_mode && !rx_mpb);
  assign addr_wait_mode_clr = rx_done && mp_on && rx_mpb;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_st_reg   <= MDSP_IDLE;
      rx_sh_reg   <= 9'h000;
      rx_tick_reg <= 4'h0;
      rx_bits_reg <= 4'h0;
    end else if (clk_en) begin
      if (!rx_en || !bclk_ok) begin
        rx_st_reg <= MDSP_IDLE;
      end else if (tick) begin
        rx_tick_reg <= rx_tick_reg + 4'h1;
        case (rx_st_reg)
          MDSP_IDLE: begin
            rx_tick_reg <= 4'h0;
            if (!rx_s2_reg) rx_st_reg <= MDSP_START;
          end
          MDSP_START: if (rx_tick_reg == MDSP_MID_TICK) begin
            rx_tick_reg <= 4'h0;
            rx_bits_reg <= rx_nbits;
            rx_st_reg   <= rx_s2_reg ? MDSP_IDLE : MDSP_DATA;
          end
          MDSP_DATA: if (rx_tick_reg == 4'hf) begin
            rx_sh_reg   <= {rx_s2_reg, rx_sh_reg[8:1]};
            rx_bits_reg <= rx_bits_reg - 4'h1;
            if (rx_bits_reg == 4'h1) rx_st_reg <= MDSP_STOP;
          end
          MDSP_STOP: if (rx_tick_reg == 4'hf) begin
            rx_tick_reg <= 4'h0;
            rx_st_reg   <= MDSP_IDLE;     // Second stop not checked
          end
          default: rx_st_reg <= MDSP_IDLE;
        endcase
        // Shift right without multidrop aligns data; the top bit is left 0
        if (rx_st_reg == MDSP_STOP && rx_tick_reg == 4'h0 && !mp_on)
          rx_sh_reg <= {1'b0, rx_sh_reg[8:1]};
      end
    end
  end

  // Receive flags and holding word
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_hold_reg <= 8'h00;
      rx_hold_full_reg    <= 1'b0;
      overrun_flag_reg    <= 1'b0;
      fer_reg     <= 1'b0;
      mpb_reg     <= 1'b0;
    end else if (clk_en) begin
      if (rx_done && rx_en) mpb_reg <= rx_mpb;
      if (rx_done && rx_keep && !rx_bad && !rx_hold_full_reg)
        rx_hold_reg <= rx_word;
      // Set beats clear in the same cycle; rx_en low leaves RX_HOLD_FULL
      if (rx_done && rx_keep && !rx_bad && !rx_hold_full_reg) rx_hold_full_reg <= 1'b1;
      else if (dma_rx_rd || clr_ok(MDSP_SF_RX_HOLD_FULL)) rx_hold_full_reg <= 1'b0;
      if (rx_done && rx_keep && !rx_bad && rx_hold_full_reg) overrun_flag_reg <= 1'b1;
      else if (clr_ok(MDSP_SF_OVERRUN_FLAG)) overrun_flag_reg <= 1'b0;
      if (rx_done && rx_keep && rx_bad) fer_reg <= 1'b1;
      else if (clr_ok(MDSP_SF_FER)) fer_reg <= 1'b0;
    end
  end

  assign dma_rx_data = rx_hold_reg;

  // Interrupt requests gated by their enables
  assign tx_empty_irq = ctrl_reg[MDSP_SC_TIE] & tx_hold_empty_reg;
  assign rx_full_irq  = ctrl_reg[MDSP_SC_RIE] & rx_hold_full_reg;
  assign rx_fault_irq = ctrl_reg[MDSP_SC_RIE] & (overrun_flag_reg | fer_reg);
  assign tx_done_irq  = ctrl_reg[MDSP_SC_TX_DONE_IRQ_EN] & tx_idle_flag_reg;

endmodule : mdsp_port
